// [rtl/sar_seq_pkg.sv]
/*
  Shared constants and types for the successive-approximation
  conversion sequencer: result width, timing figures and their cycle
  counts at the 25 MHz system clock, and the sequencer states.
  Assumes a single 25 MHz clock domain.
*/
package sar_seq_pkg;

  // ==========================================================
  // Result layout
  localparam int unsigned RESULT_BITS = 10;
  localparam logic [3:0]  MSB_INDEX   = 4'h9;
  localparam logic [9:0]  MSB_CODE    = 10'h200;
  localparam logic [9:0]  CODE_RESET  = 10'h000;

  // ==========================================================
  // Clock and times in their own units
  localparam int unsigned CLK_FREQ_KHZ   = 25000;
  localparam int unsigned CONV_MIN_NS    = 15000;
  localparam int unsigned CONV_TYP_NS    = 25000;
  localparam int unsigned CONV_MAX_NS    = 40000;
  localparam int unsigned DATA_VALID_NS  = 500;
  localparam int unsigned RELEASE_NS     = 1500;
  localparam int unsigned CLEAR_PULSE_NS = 2000;

  // ==========================================================
  // Cycle counts: least times round up, longest times round down
  localparam int unsigned CONV_MIN_CYC =
    (CONV_MIN_NS * CLK_FREQ_KHZ + 999999) / 1000000;
  localparam int unsigned CONV_MAX_CYC =
    (CONV_MAX_NS * CLK_FREQ_KHZ) / 1000000;
  localparam int unsigned DATA_VALID_CYC =
    (DATA_VALID_NS * CLK_FREQ_KHZ) / 1000000;
  localparam int unsigned RELEASE_CYC =
    (RELEASE_NS * CLK_FREQ_KHZ) / 1000000;
  localparam int unsigned CLEAR_PULSE_CYC =
    (CLEAR_PULSE_NS * CLK_FREQ_KHZ + 999999) / 1000000;
  // Per-bit trial time aims at the typical total conversion time
  localparam int unsigned BIT_CYC =
    (CONV_TYP_NS * CLK_FREQ_KHZ) / 1000000 / RESULT_BITS;

  // Counter width for bit timer and blank-high timer
  localparam int unsigned CNT_W = 7;

  // ==========================================================
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_HALT,
    ST_DONE
  } state_type;

endpackage

// [rtl/pin_sync.sv]
/*
  Two-flop synchroniser, one chain per bit.
  Assumes the inputs are asynchronous pins and dst clock is clk.
*/
`timescale 1ns/1ps

module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ==========================================================
  // Per-bit chains; first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_chain
      logic meta_q;
      logic stable_q;
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_q   <= 1'b0;
          stable_q <= 1'b0;
        end else begin
          meta_q   <= async_in[gi];
          stable_q <= meta_q;
        end
      end
      assign sync_out[gi] = stable_q;
    end
  endgenerate

endmodule // pin_sync

// [rtl/sar_conversion_sequencer.sv]
/*
  Control logic of a 10-bit successive-approximation converter:
  bit trials against a comparator, result-valid handshake and
  three-state data output control driven by the blank/convert line.
  Assumes the host, comparator and bipolar strap are asynchronous to
  clk; the analogue DAC consumes dac_code and offset_en outside.
*/
// How it works
// RULE_01: A start command trials all ten bits, most significant first.
// RULE_02: Each trial sets the bit, then clears it if comparator says above.
// RULE_03: After the last trial the register holds the 10-bit result code.
// RULE_04: Completion pulls result_valid_n low and enables the data outputs.
// RULE_05: Blank/convert high floats outputs and clears the register.
// RULE_06: Bipolar select switches the offset in; coding follows from it.
// RULE_07: Start to result-valid takes between 15 and 40 microseconds.
// RULE_08: Data is valid within 500 ns of result-valid falling.
// RULE_09: Outputs release about 1.5 us after blank/convert rises.
// RULE_10: Blank/convert high mid-conversion halts; outputs unchanged.
// RULE_11: Host holds blank/convert high 2 us; that restarts conversion.
// RULE_12: A bit timer that counts only while converting and a 9-to-0 bit counter pace trials.
`timescale 1ns/1ps

module sar_conversion_sequencer (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       blank_convert,
  input  wire logic       bipolar_sel,
  input  wire logic       comp_above,
  output logic [9:0]      dac_code_q,
  output logic            offset_en_q,
  output logic            result_valid_n_q,
  output logic [9:0]      data_q,
  output logic            data_oe_n_q
);

  // ==========================================================
  // Signals
  localparam logic [6:0] BIT_LAST =
    7'(sar_seq_pkg::BIT_CYC - 1); // RULE_07
  localparam logic [6:0] RELEASE_LAST =
    7'(sar_seq_pkg::RELEASE_CYC - 1);
  localparam logic [6:0] CLEAR_CNT =
    7'(sar_seq_pkg::CLEAR_PULSE_CYC);
  localparam logic [6:0] HOLD_MAX = 7'h7F;

  sar_seq_pkg::state_type state_q;
  logic [2:0] pins_s;
  logic       blank_s;
  logic       bipolar_s;
  logic       above_s;
  logic [3:0] bit_idx_q;
  logic [6:0] bit_tmr_q;
  logic [6:0] hold_q;
  logic       bit_end;
  logic       start;
  logic       long_pulse;
  logic       release_now;
  logic [9:0] decided;
  logic [1:0] settle_q;

  // ==========================================================
  // Pin synchronisers
  pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({comp_above, bipolar_sel, blank_convert}),
    .sync_out (pins_s)
  );
  assign blank_s   = pins_s[0];
  assign bipolar_s = pins_s[1];
  assign above_s   = pins_s[2];

  // ==========================================================
  // Decode of events
  assign bit_end     = (state_q == sar_seq_pkg::ST_CONV) && !blank_s &&
                       (bit_tmr_q == BIT_LAST);
  assign long_pulse  = (hold_q >= CLEAR_CNT);
  assign start       = settle_q[1] && !blank_s &&
                       ((state_q == sar_seq_pkg::ST_IDLE) ||
                        ((state_q == sar_seq_pkg::ST_HALT) && long_pulse));
  assign release_now = (state_q == sar_seq_pkg::ST_DONE) && blank_s &&
                       (hold_q == RELEASE_LAST);

  // ==========================================================
  // Start hold-off after reset: the synchronisers come out of reset
  // reading convert, which would launch a false conversion
  always_ff @(posedge clk) begin
    if (rst) begin
      settle_q <= 2'h0;
    end else begin
      settle_q <= {settle_q[0], 1'b1};
    end
  end

  // Trial bit kept or dropped by the sampled comparator
  always_comb begin
    decided = dac_code_q;
    if (above_s) begin
      decided[bit_idx_q] = 1'b0; // RULE_02
    end
  end

  // ==========================================================
  // Sequencer state
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= sar_seq_pkg::ST_IDLE;
    end else begin
      case (state_q)
        sar_seq_pkg::ST_IDLE: begin
          if (start) state_q <= sar_seq_pkg::ST_CONV; // RULE_01
        end
        sar_seq_pkg::ST_CONV: begin
          if (blank_s) begin
            state_q <= sar_seq_pkg::ST_HALT; // RULE_10
          end else if (bit_end && bit_idx_q == 4'h0) begin
            state_q <= sar_seq_pkg::ST_DONE;
          end
        end
        sar_seq_pkg::ST_HALT: begin
          // Short pulse resumes; a long one restarts from the MSB
          if (!blank_s) state_q <= sar_seq_pkg::ST_CONV; // RULE_11
        end
        sar_seq_pkg::ST_DONE: begin
          if (release_now) state_q <= sar_seq_pkg::ST_IDLE;
        end
        default: state_q <= sar_seq_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Blank-high duration, saturating so a long hold never wraps
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_q <= 7'h00;
    end else if (!blank_s) begin
      hold_q <= 7'h00;
    end else if (hold_q != HOLD_MAX) begin
      hold_q <= hold_q + 7'h01;
    end
  end

  // ==========================================================
  // Bit timer: freezes while halted so a short pulse only pauses
  always_ff @(posedge clk) begin
    if (rst) begin
      bit_tmr_q <= 7'h00;
    end else if (start) begin
      bit_tmr_q <= 7'h00;
    end else if (state_q == sar_seq_pkg::ST_CONV && !blank_s) begin
      bit_tmr_q <= bit_end ? 7'h00 : bit_tmr_q + 7'h01; // RULE_12
    end
  end

  // ==========================================================
  // Approximation register and bit position
  always_ff @(posedge clk) begin
    if (rst) begin
      dac_code_q <= sar_seq_pkg::CODE_RESET;
      bit_idx_q  <= sar_seq_pkg::MSB_INDEX;
    end else if (start) begin
      dac_code_q <= sar_seq_pkg::MSB_CODE; // RULE_01
      bit_idx_q  <= sar_seq_pkg::MSB_INDEX;
    end else if (bit_end) begin
      if (bit_idx_q != 4'h0) begin
        dac_code_q <= decided | (10'h001 << (bit_idx_q - 4'h1)); // RULE_01
        bit_idx_q  <= bit_idx_q - 4'h1; // RULE_12
      end else begin
        dac_code_q <= decided; // RULE_03
      end
    end else if (release_now) begin
      dac_code_q <= sar_seq_pkg::CODE_RESET; // RULE_05
    end
  end

  // ==========================================================
  // Offset switch, latched per conversion so the range never
  // changes in the middle of a trial sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      offset_en_q <= 1'b0;
    end else if (start) begin
      offset_en_q <= bipolar_s; // RULE_06
    end
  end

  // ==========================================================
  // Result handshake and output drivers; data loads on the same
  // edge as result_valid_n so it is valid with no extra delay
  always_ff @(posedge clk) begin
    if (rst) begin
      result_valid_n_q <= 1'b1;
      data_oe_n_q      <= 1'b1;
      data_q           <= sar_seq_pkg::CODE_RESET;
    end else if (bit_end && bit_idx_q == 4'h0) begin
      result_valid_n_q <= 1'b0; // RULE_04
      data_oe_n_q      <= 1'b0; // RULE_04
      data_q           <= decided; // RULE_08
    end else if (release_now) begin
      result_valid_n_q <= 1'b1; // RULE_09
      data_oe_n_q      <= 1'b1; // RULE_05
    end
  end

  // ==========================================================
  // Checks
  localparam int unsigned REL_HOLD = sar_seq_pkg::RELEASE_CYC;
  logic [10:0] conv_len_q;

  // Cycles spent converting since the last start
  always_ff @(posedge clk) begin
    if (rst || start) begin
      conv_len_q <= 11'h000;
    end else if (state_q == sar_seq_pkg::ST_CONV && !blank_s &&
                 conv_len_q != 11'h7FF) begin
      conv_len_q <= conv_len_q + 11'h001;
    end
  end

  a_conv_time_window: assert property ( // RULE_07
    @(posedge clk) disable iff (rst)
    $fell(result_valid_n_q) |->
      (conv_len_q >= 11'(sar_seq_pkg::CONV_MIN_CYC)) &&
      (conv_len_q <= 11'(sar_seq_pkg::CONV_MAX_CYC)))
    else $error("conversion time outside window");

  a_start_msb_first: assert property ( // RULE_01
    @(posedge clk) disable iff (rst)
    start |=> (dac_code_q == sar_seq_pkg::MSB_CODE) &&
              (bit_idx_q == sar_seq_pkg::MSB_INDEX))
    else $error("conversion did not start at msb");

  a_bit_step_down: assert property (@(posedge clk) disable iff (rst) // RULE_12
    (bit_end && bit_idx_q != 4'h0) |=>
      (bit_idx_q == $past(bit_idx_q) - 4'h1) && (bit_tmr_q == 7'h00))
    else $error("bit position did not step down");

  a_trial_dropped: assert property (@(posedge clk) disable iff (rst) // RULE_02
    (bit_end && above_s) |=> !dac_code_q[$past(bit_idx_q)])
    else $error("trial bit kept although sum above input");

  a_result_on_data: assert property ( // RULE_04
    @(posedge clk) disable iff (rst)
    $fell(result_valid_n_q) |->
      !data_oe_n_q && (data_q == dac_code_q) ##1 $stable(data_q))
    else $error("data not driven with result valid");

  a_release_delay: assert property (@(posedge clk) disable iff (rst) // RULE_09
    $rose(result_valid_n_q) |->
      data_oe_n_q && (hold_q == 7'(REL_HOLD)) &&
      (dac_code_q == sar_seq_pkg::CODE_RESET))
    else $error("release not 1.5 us after blank");

  a_halt_frozen: assert property (@(posedge clk) disable iff (rst) // RULE_10
    (state_q == sar_seq_pkg::ST_HALT && blank_s) |=>
      $stable(result_valid_n_q) && $stable(data_oe_n_q) &&
      $stable(dac_code_q) && $stable(bit_idx_q))
    else $error("halted conversion changed outputs");

  a_long_restart: assert property (@(posedge clk) disable iff (rst) // RULE_11
    (state_q == sar_seq_pkg::ST_HALT && !blank_s && long_pulse) |=>
      (dac_code_q == sar_seq_pkg::MSB_CODE) && (bit_tmr_q == 7'h00))
    else $error("long blank pulse did not restart");

  a_offset_steady: assert property (@(posedge clk) disable iff (rst) // RULE_06
    (state_q == sar_seq_pkg::ST_CONV) && !start |=> $stable(offset_en_q))
    else $error("offset switch moved mid conversion");

  c_conv_done: cover property (@(posedge clk) disable iff (rst)
    $fell(result_valid_n_q));
  c_halt_resume: cover property (@(posedge clk) disable iff (rst)
    state_q == sar_seq_pkg::ST_HALT && !blank_s && !long_pulse);
  c_long_restart: cover property (@(posedge clk) disable iff (rst)
    state_q == sar_seq_pkg::ST_HALT && !blank_s && long_pulse);
  c_release: cover property (@(posedge clk) disable iff (rst)
    $rose(result_valid_n_q));

endmodule // sar_conversion_sequencer

// [tb/analog_front_model.sv]
/*
  Behavioural model of the far side of the sequencer: input signal,
  bipolar offset switch and comparator, in units of one result step.
  Assumes dac_code and offset_en come straight from the sequencer.
*/
`timescale 1ns/1ps

module analog_front_model (
  input  wire logic               clk,
  input  wire logic [9:0]         dac_code,
  input  wire logic               offset_en,
  input  wire logic signed [10:0] vin,
  output logic                    comp_above
);
  // ==========================================================
  // Comparator
  logic signed [11:0] target;

  // Offset shifts a bipolar input up by half scale
  assign target = offset_en ? 12'(vin) + 12'sd512 : 12'(vin);

  // Above only when the trial sum exceeds the input; equal keeps bit
  always @(posedge clk) begin
    comp_above <= #2 ($signed({2'h0, dac_code}) > target);
  end
endmodule // analog_front_model

// [tb/testbench.sv]
/*
  Self-checking bench for the conversion sequencer: whole conversions,
  boundary and random inputs in both modes, short halt and restart.
  Assumes the design takes its inputs through two-flop synchronisers.
*/
`timescale 1ns/1ps

module testbench;
  // ==========================================================
  // Signals
  logic               clk;
  logic               rst;
  logic               blank_convert;
  logic               bipolar_sel;
  logic               comp_above;
  logic [9:0]         dac_code_q;
  logic               offset_en_q;
  logic               result_valid_n_q;
  logic [9:0]         data_q;
  logic               data_oe_n_q;
  logic signed [10:0] vin;
  logic [9:0]         exp_q[$];
  int                 cyc;
  int                 t_start;
  int                 n_fail;
  int                 checks;

  sar_conversion_sequencer sar_conversion_sequencer_inst (
    .clk(clk), .rst(rst), .blank_convert(blank_convert),
    .bipolar_sel(bipolar_sel), .comp_above(comp_above),
    .dac_code_q(dac_code_q), .offset_en_q(offset_en_q),
    .result_valid_n_q(result_valid_n_q), .data_q(data_q),
    .data_oe_n_q(data_oe_n_q));

  analog_front_model analog_front_model_inst (
    .clk(clk), .dac_code(dac_code_q), .offset_en(offset_en_q),
    .vin(vin), .comp_above(comp_above));

  // ==========================================================
  // Clock, cycle count and hang guard
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // Whole run needs about 6500 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc >= 20000) begin
      n_fail++;
      complete_run();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen,
               exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Inputs always move 2 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // One conversion; optional blank pulse after halt_at cycles
  task automatic run_conv(input logic signed [10:0] v, input logic bip,
                          input int halt_at, input int halt_len,
                          input logic signed [10:0] v2);
    logic [9:0] frozen;
    int         w;
    bipolar_sel = bip;
    vin = v;
    tick(6);
    exp_q.push_back(bip ? 10'(v2 + 11'sd512) : 10'(v2));
    blank_convert = 1'b0;
    t_start = cyc;
    tick(5);
    check(dac_code_q, 10'h200);
    check(offset_en_q, bip);
    if (halt_len > 0) begin
      tick(halt_at);
      blank_convert = 1'b1;
      tick(halt_len / 2);
      frozen = dac_code_q;
      check(result_valid_n_q, 1'b1);
      tick(halt_len / 2);
      check(data_oe_n_q, 1'b1);
      check(dac_code_q, frozen);
      vin = v2;
      blank_convert = 1'b0;
      if (halt_len >= 50) begin
        t_start = cyc;
        tick(5);
        check(dac_code_q, 10'h200);
      end
    end
    w = 0;
    while (result_valid_n_q !== 1'b0 && w < 1200) begin
      tick(1);
      w++;
    end
    check(w < 1200, 1'b1);
    tick(3);
    // Host returns blank high; release comes about 37 cycles later
    blank_convert = 1'b1;
    tick(30);
    check(result_valid_n_q, 1'b0);
    tick(15);
    check(result_valid_n_q, 1'b1);
    check(data_oe_n_q, 1'b1);
    check(dac_code_q, 10'h000);
  endtask

  // ==========================================================
  // Result watcher: one note taken per falling result-valid
  always @(negedge result_valid_n_q) begin
    if (!rst) begin
      #1;
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else check(data_q, exp_q.pop_front());
      check(data_oe_n_q, 1'b0);
      check(32'(cyc - t_start >= 375 && cyc - t_start <= 1000), 1);
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    int r;
    logic b;
    rst = 1'b1;
    blank_convert = 1'b1;
    bipolar_sel = 1'b0;
    vin = '0;
    void'($urandom(32'h8cec));
    tick(6);
    rst = 1'b0;
    tick(4);
    // Scale ends in both codings
    run_conv(11'sd0, 1'b0, 0, 0, 11'sd0);
    run_conv(11'sd1023, 1'b0, 0, 0, 11'sd1023);
    run_conv(-11'sd512, 1'b1, 0, 0, -11'sd512);
    run_conv(11'sd511, 1'b1, 0, 0, 11'sd511);
    for (int i = 0; i < 3; i++) begin
      b = 1'($urandom_range(1, 0));
      r = $urandom_range(1023, 0);
      r = b ? r - 512 : r;
      run_conv(11'(r), b, 0, 0, 11'(r));
    end
    // Short pulse pauses; long pulse restarts on a new input
    run_conv(11'sd300, 1'b0, 200, 20, 11'sd300);
    run_conv(11'sd0, 1'b0, 300, 60, 11'sd1023);
    complete_run();
  end
endmodule // testbench
